// [verilog/fault_pkg.sv]
// What this block does
// [RULE1] latched fault holds until cause removed, clear
// [RULE2] current above 200 percent trips overcurrent
// [RULE3] ground fault flag trips ground fault
// [RULE4] 150 percent for one minute trips overload
// [RULE5] timer runs at 150 percent, trips overload
// [RULE6] heat sink overheat flag trips overheat
// [RULE7] capacitor replacement due trips capacitor fault
// [RULE8] any open output phase trips phase loss
// [RULE9] bus above 400 volts trips overvoltage
// [RULE10] bus below 180 volts trips low voltage
// [RULE11] thermal model overload trips electronic thermal
// [RULE12] storage write failure raises save error
// [RULE13] control circuitry error raises hardware fault
// [RULE14] keypad link loss raises communication error
// [RULE15] fan fault input raises cooling fan fault
// [RULE16] emergency cutoff disables output at once
// [RULE17] cutoff release with run held resumes
// [RULE18] open-sense external input on trips fault A
// [RULE19] closed-sense external input trips fault B
// [RULE20] lost analog or serial reference applies action
// [RULE21] action 0 continue, 1 coast, 2 decel
// [RULE22] closed sense trips off, open sense on
// [RULE23] code shown; combined disable while latched
package fault_pkg;

  // ----------------------------------------
  // fault codes shown on the display
  // ----------------------------------------
  typedef enum logic [4:0] {
    code_none,
    code_overcurrent,
    code_ground,
    code_drive_overload,
    code_overload_trip,
    code_heatsink,
    code_capacitor,
    code_phase_loss,
    code_overvoltage,
    code_low_voltage,
    code_thermal,
    code_save_error,
    code_hardware,
    code_comm_error,
    code_fan,
    code_cutoff,
    code_ext_a,
    code_ext_b
  } fault_code_t;

  // ----------------------------------------
  // input function and loss action codes
  // ----------------------------------------
  localparam logic [4:0] func_ext_fault = 5'h13;
  localparam logic [1:0] loss_continue  = 2'h0;
  localparam logic [1:0] loss_coast     = 2'h1;
  localparam logic [1:0] loss_decel     = 2'h2;
  localparam int         num_inputs     = 5;

  // ----------------------------------------
  // thresholds, current in percent, bus in volts
  // ----------------------------------------
  localparam logic [9:0]  oc_pct      = 10'h0C8;
  localparam logic [9:0]  ol_pct      = 10'h096;
  localparam logic [9:0]  ov_volts    = 10'h190;
  localparam logic [9:0]  uv_volts    = 10'h0B4;
  localparam int          ol_time_s   = 60;
  localparam longint      clk_hz      = 100000000;
  localparam longint      ol_cycles_d = ol_time_s * clk_hz;

endpackage

// [verilog/trip_if.sv]
`timescale 1ns/1ps
interface trip_if;
  logic       overload_trip;
  logic [2:0] phase_open;
  modport src (output overload_trip, output phase_open);
  modport dst (input overload_trip, input phase_open);
endinterface

// [verilog/overload_timer.sv]
`timescale 1ns/1ps
module overload_timer #(
  parameter logic [32:0] limit = 33'(fault_pkg::ol_cycles_d)
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [9:0] current_pct,
  input  wire logic [2:0] phase_current_ok,
  input  wire logic       running,
  trip_if.src             trips
);
  logic [32:0] count;
  logic [32:0] next_count;
  logic        hit;
  logic        next_hit;

  always_comb
  begin
    next_count = 33'h0_0000_0000;
    next_hit   = hit;
    if (current_pct >= fault_pkg::ol_pct)
    begin
      // saturating so a long overload never wraps back to safe
      next_count = (count == limit) ? count : count + 33'h0_0000_0001; // [RULE5]
    end
    if (count == limit)
      next_hit = 1'b1; // [RULE4]
    else
      next_hit = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= 33'h0_0000_0000;
      hit   <= 1'b0;
    end
    else
    begin
      count <= next_count;
      hit   <= next_hit;
    end
  end

  assign trips.overload_trip = hit;
  // phase is open only when the drive runs and sees no current there
  assign trips.phase_open    = running ? ~phase_current_ok : 3'h0; // [RULE8]

  chk_timer_trip: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE5]
    (count == limit) |=> hit)
    else $error("overload timer did not trip");
  chk_timer_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE4]
    (current_pct < fault_pkg::ol_pct) |=> (count == 33'h0_0000_0000))
    else $error("overload timer not cleared");
endmodule

// [verilog/drive_fault_supervisor.sv]
`timescale 1ns/1ps
module drive_fault_supervisor #(
  parameter logic [32:0] overload_cycles = 33'(fault_pkg::ol_cycles_d)
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [9:0]  current_pct,
  input  wire logic [9:0]  bus_volts,
  input  wire logic [2:0]  phase_current_ok,
  input  wire logic        ground_fault,
  input  wire logic        heatsink_hot,
  input  wire logic        capacitor_due,
  input  wire logic        thermal_overload,
  input  wire logic        save_failed,
  input  wire logic        control_error,
  input  wire logic        keypad_lost,
  input  wire logic        fan_fault,
  input  wire logic        cutoff_in,
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic [4:0]  terminal_in,
  input  wire logic [24:0] input_function_select,
  input  wire logic [4:0]  input_closed_sense,
  input  wire logic        ref_external,
  input  wire logic        ref_present,
  input  wire logic [1:0]  reference_loss_action,
  input  wire logic        fault_clear,
  output logic [4:0]       display_code,
  output logic             output_disable,
  output logic             hold_last_freq,
  output logic             decel_stop,
  output logic             fault_active
);
  // ----------------------------------------
  // external fault decode
  // ----------------------------------------
  function automatic logic ext_trip(input logic [24:0] sel, input logic [4:0] pins,
                                    input logic [4:0] sense, input logic want_closed);
    logic r;
    r = 1'b0;
    for (int i = 0; i < fault_pkg::num_inputs; i++)
    begin
      if (sel[i*5 +: 5] == fault_pkg::func_ext_fault && sense[i] == want_closed)
        r = r | (want_closed ? ~pins[i] : pins[i]); // [RULE22]
    end
    return r;
  endfunction

  trip_if trips ();

  overload_timer #(
    .limit (overload_cycles)
  ) u_timer (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .current_pct      (current_pct),
    .phase_current_ok (phase_current_ok),
    .running          (forward_run_input | reverse_run_input),
    .trips            (trips.src)
  );

  // ----------------------------------------
  // cause detection, highest priority first
  // ----------------------------------------
  fault_pkg::fault_code_t cause;
  logic ext_a;
  logic ext_b;
  logic ref_lost;

  assign ext_a    = ext_trip(input_function_select, terminal_in, input_closed_sense, 1'b0);
  assign ext_b    = ext_trip(input_function_select, terminal_in, input_closed_sense, 1'b1);
  assign ref_lost = ref_external & ~ref_present; // [RULE20]

  always_comb
  begin
    cause = fault_pkg::code_none;
    if (current_pct > fault_pkg::oc_pct)
      cause = fault_pkg::code_overcurrent; // [RULE2]
    else if (ground_fault)
      cause = fault_pkg::code_ground; // [RULE3]
    else if (bus_volts > fault_pkg::ov_volts)
      cause = fault_pkg::code_overvoltage; // [RULE9]
    else if (bus_volts < fault_pkg::uv_volts)
      cause = fault_pkg::code_low_voltage; // [RULE10]
    else if (trips.overload_trip)
      cause = fault_pkg::code_overload_trip; // [RULE5] [RULE4]
    else if (heatsink_hot)
      cause = fault_pkg::code_heatsink; // [RULE6]
    else if (capacitor_due)
      cause = fault_pkg::code_capacitor; // [RULE7]
    else if (|trips.phase_open)
      cause = fault_pkg::code_phase_loss; // [RULE8]
    else if (thermal_overload)
      cause = fault_pkg::code_thermal; // [RULE11]
    else if (control_error)
      cause = fault_pkg::code_hardware; // [RULE13]
    else if (save_failed)
      cause = fault_pkg::code_save_error; // [RULE12]
    else if (keypad_lost)
      cause = fault_pkg::code_comm_error; // [RULE14]
    else if (fan_fault)
      cause = fault_pkg::code_fan; // [RULE15]
    else if (ext_a)
      cause = fault_pkg::code_ext_a; // [RULE18]
    else if (ext_b)
      cause = fault_pkg::code_ext_b; // [RULE19]
  end

  // ----------------------------------------
  // fault latch
  // ----------------------------------------
  fault_pkg::fault_code_t latched;
  fault_pkg::fault_code_t next_latched;
  logic                   active_cause;

  assign active_cause = (cause != fault_pkg::code_none);

  always_comb
  begin
    next_latched = latched;
    if (latched == fault_pkg::code_none && active_cause)
      next_latched = cause;
    // clear only after every cause has gone; a new cause beats the clear
    else if (fault_clear && !active_cause)
      next_latched = fault_pkg::code_none; // [RULE1]
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      latched <= fault_pkg::code_none;
    else
      latched <= next_latched;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic [4:0] next_display;
  logic       next_hold;
  logic       next_decel;
  logic       loss_coast_cut;

  assign loss_coast_cut = ref_lost && reference_loss_action == fault_pkg::loss_coast; // [RULE21]

  always_comb
  begin
    next_display = latched;
    if (latched == fault_pkg::code_none && cutoff_in)
      next_display = fault_pkg::code_cutoff;
    next_hold  = ref_lost && reference_loss_action == fault_pkg::loss_continue; // [RULE21]
    next_decel = ref_lost && reference_loss_action == fault_pkg::loss_decel; // [RULE21]
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      display_code   <= 5'h00;
      hold_last_freq <= 1'b0;
      decel_stop     <= 1'b0;
    end
    else
    begin
      display_code   <= next_display; // [RULE23]
      hold_last_freq <= next_hold;
      decel_stop     <= next_decel;
    end
  end

  // cutoff acts combinationally so no ramp or clock delay precedes it;
  // release resumes as soon as cutoff drops if a run input is held
  assign output_disable = (latched != fault_pkg::code_none) | cutoff_in // [RULE16] [RULE23]
                        | loss_coast_cut
                        | ~(forward_run_input | reverse_run_input); // [RULE17]
  assign fault_active   = (latched != fault_pkg::code_none);

  // ----------------------------------------
  // checks on the fault latch
  // ----------------------------------------
  chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE1]
    (latched != fault_pkg::code_none && active_cause) |=> (latched == $past(latched)))
    else $error("fault released while cause present");

  chk_clear_done: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE1]
    (latched != fault_pkg::code_none && fault_clear && !active_cause)
    |=> latched == fault_pkg::code_none)
    else $error("clear ignored with no cause present");

  chk_disable_latched: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE23]
    (latched != fault_pkg::code_none) |-> output_disable ##1 display_code == $past(latched))
    else $error("latched fault not shown");

  chk_idle_display: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE23]
    (latched == fault_pkg::code_none && !cutoff_in) |=> display_code == 5'h00)
    else $error("display not blank while healthy");

  // ----------------------------------------
  // checks on the trip codes
  // ----------------------------------------
  chk_oc_trip: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE2]
    (latched == fault_pkg::code_none && current_pct > fault_pkg::oc_pct)
    |=> latched == fault_pkg::code_overcurrent)
    else $error("overcurrent not latched");

  chk_ground_trip: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE3]
    (latched == fault_pkg::code_none && ground_fault && current_pct <= fault_pkg::oc_pct)
    |=> latched == fault_pkg::code_ground)
    else $error("ground fault not latched");

  chk_ov_trip: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE9]
    (latched == fault_pkg::code_none && bus_volts > fault_pkg::ov_volts
     && current_pct <= fault_pkg::oc_pct && !ground_fault)
    |=> latched == fault_pkg::code_overvoltage)
    else $error("overvoltage not latched");

  chk_uv_trip: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE10]
    (latched == fault_pkg::code_none && bus_volts < fault_pkg::uv_volts
     && current_pct <= fault_pkg::oc_pct && !ground_fault)
    |=> latched == fault_pkg::code_low_voltage)
    else $error("low voltage not latched");

  // ----------------------------------------
  // checks that each cause raises the fault; the save, hardware, comm and fan checks do not test the cut
  // ----------------------------------------
  // a cause held over an edge either fills the empty latch or blocks its clear,
  // so these hold whichever code the priority order picks
  chk_overload_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE5]
    trips.overload_trip |=> fault_active && output_disable)
    else $error("overload trip did not cut output");

  chk_heat_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE6]
    heatsink_hot |=> fault_active && output_disable)
    else $error("heat sink overheat did not cut output");

  chk_capacitor_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE7]
    capacitor_due |=> fault_active && output_disable)
    else $error("capacitor fault did not cut output");

  chk_phase_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE8]
    ((forward_run_input || reverse_run_input) && phase_current_ok != 3'h7)
    |=> fault_active && output_disable)
    else $error("open phase did not cut output");

  chk_thermal_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE11]
    thermal_overload |=> fault_active && output_disable)
    else $error("thermal overload did not cut output");

  chk_save_shown: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE12]
    save_failed |=> fault_active)
    else $error("save error not raised");

  chk_hw_shown: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE13]
    control_error |=> fault_active)
    else $error("hardware fault not raised");

  chk_comm_shown: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE14]
    keypad_lost |=> fault_active)
    else $error("communication error not raised");

  chk_fan_shown: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE15]
    fan_fault |=> fault_active)
    else $error("cooling fan fault not raised");

  chk_ext_a_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE18] [RULE22]
    ext_a |=> fault_active && output_disable)
    else $error("external fault A did not cut output");

  chk_ext_b_cut: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE19] [RULE22]
    ext_b |=> fault_active && output_disable)
    else $error("external fault B did not cut output");

  // ----------------------------------------
  // checks on cutoff and reference loss
  // ----------------------------------------
  chk_cut_now: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE16]
    cutoff_in |-> output_disable)
    else $error("cutoff did not disable output");

  chk_cut_shown: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE16]
    (latched == fault_pkg::code_none && cutoff_in)
    |=> display_code == fault_pkg::code_cutoff)
    else $error("cutoff not shown");

  chk_resume_run: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE17]
    (!cutoff_in && forward_run_input && latched == fault_pkg::code_none && !ref_lost)
    |-> !output_disable)
    else $error("no resume after cutoff release");

  chk_loss_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE21]
    (ref_lost && reference_loss_action == fault_pkg::loss_continue)
    |=> hold_last_freq)
    else $error("continue action not applied");

  chk_loss_coast: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE21]
    (ref_lost && reference_loss_action == fault_pkg::loss_coast)
    |-> output_disable)
    else $error("coast action did not cut output");

  chk_loss_decel: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE21]
    (ref_lost && reference_loss_action == fault_pkg::loss_decel) |=> decel_stop)
    else $error("decel action not applied");

  chk_ref_back: assert property (@(posedge sys_clk) disable iff (!rstn) // [RULE20]
    !ref_lost |=> !hold_last_freq && !decel_stop)
    else $error("loss action applied with reference present");

  // ----------------------------------------
  // scenarios worth seeing
  // ----------------------------------------
  cov_oc: cover property (@(posedge sys_clk) latched == fault_pkg::code_overcurrent);
  cov_clear: cover property (@(posedge sys_clk)
    latched != fault_pkg::code_none ##1 latched == fault_pkg::code_none);
  cov_ext_b: cover property (@(posedge sys_clk) latched == fault_pkg::code_ext_b);
  cov_cutoff: cover property (@(posedge sys_clk) cutoff_in ##1 !cutoff_in);
  cov_overload: cover property (@(posedge sys_clk) latched == fault_pkg::code_overload_trip);
endmodule

// [verification/power_stage_model.sv]
`timescale 1ns/1ps
module power_stage_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       output_disable,
  input  wire logic [9:0] load_pct,
  input  wire logic [2:0] open_mask,
  output logic      [9:0] current_pct,
  output logic      [2:0] phase_current_ok
);
  // current follows the load a cycle late; it vanishes once the bridge is off,
  // so an overcurrent cause clears itself after the trip
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      current_pct <= 10'h000;
    else if (output_disable)
      current_pct <= 10'h000;
    else
      current_pct <= load_pct;
  // an open phase carries no current whatever the bridge does
  assign phase_current_ok = ~open_mask;
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    total_checks = total_checks + 1; \
    if ((got) !== (exp)) \
    begin \
      errors = errors + 1; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module testbench;
  localparam logic [32:0] ol_cycles = 33'h0_0000_0014;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [9:0]  load_pct = 10'h064;
  logic [9:0]  bus_volts = 10'h12C;
  logic [2:0]  open_mask = 3'h0;
  logic [9:0]  current_pct;
  logic [2:0]  phase_current_ok;
  logic        ground_fault = 1'b0, heatsink_hot = 1'b0, capacitor_due = 1'b0;
  logic        thermal_overload = 1'b0, save_failed = 1'b0, control_error = 1'b0;
  logic        keypad_lost = 1'b0, fan_fault = 1'b0, cutoff_in = 1'b0, fault_clear = 1'b0;
  logic        forward_run_input = 1'b1, reverse_run_input = 1'b0;
  logic [4:0]  terminal_in = 5'h10;
  logic [24:0] input_function_select = 25'h139_8000;
  logic [4:0]  input_closed_sense = 5'h10;
  logic        ref_external = 1'b0, ref_present = 1'b1;
  logic [1:0]  reference_loss_action = 2'h0;
  logic [4:0]  display_code;
  logic        output_disable, hold_last_freq, decel_stop, fault_active;
  int          errors = 0;
  int          total_checks = 0;
  integer      seed = 32'hb2571f9a;
  int          n;
  fault_pkg::fault_code_t code_of [14] = '{fault_pkg::code_overcurrent,
    fault_pkg::code_ground, fault_pkg::code_overvoltage, fault_pkg::code_low_voltage,
    fault_pkg::code_heatsink, fault_pkg::code_capacitor, fault_pkg::code_phase_loss,
    fault_pkg::code_thermal, fault_pkg::code_hardware, fault_pkg::code_save_error,
    fault_pkg::code_comm_error, fault_pkg::code_fan, fault_pkg::code_ext_a,
    fault_pkg::code_ext_b};

  always #5 sys_clk = ~sys_clk;

  power_stage_model stage (.sys_clk(sys_clk), .rstn(rstn), .output_disable(output_disable),
    .load_pct(load_pct), .open_mask(open_mask), .current_pct(current_pct),
    .phase_current_ok(phase_current_ok));

  drive_fault_supervisor #(.overload_cycles(ol_cycles)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .current_pct(current_pct), .bus_volts(bus_volts), .phase_current_ok(phase_current_ok),
    .ground_fault(ground_fault), .heatsink_hot(heatsink_hot), .capacitor_due(capacitor_due),
    .thermal_overload(thermal_overload), .save_failed(save_failed),
    .control_error(control_error), .keypad_lost(keypad_lost), .fan_fault(fan_fault),
    .cutoff_in(cutoff_in), .forward_run_input(forward_run_input),
    .reverse_run_input(reverse_run_input), .terminal_in(terminal_in),
    .input_function_select(input_function_select), .input_closed_sense(input_closed_sense),
    .ref_external(ref_external), .ref_present(ref_present),
    .reference_loss_action(reference_loss_action), .fault_clear(fault_clear),
    .display_code(display_code), .output_disable(output_disable),
    .hold_last_freq(hold_last_freq), .decel_stop(decel_stop), .fault_active(fault_active));

  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one cause at a time; the closed-sense terminal trips when it goes off
  task automatic set_cause(input int k, input logic on);
    case (k)
      0: load_pct <= on ? 10'h0C9 : 10'h064;
      1: ground_fault <= on;
      2: bus_volts <= on ? 10'h191 : 10'h12C;
      3: bus_volts <= on ? 10'h0B3 : 10'h12C;
      4: heatsink_hot <= on;
      5: capacitor_due <= on;
      6: open_mask <= on ? 3'h2 : 3'h0;
      7: thermal_overload <= on;
      8: control_error <= on;
      9: save_failed <= on;
      10: keypad_lost <= on;
      11: fan_fault <= on;
      12: terminal_in[3] <= on;
      default: terminal_in[4] <= !on;
    endcase
  endtask

  task automatic trip(input int k);
    set_cause(k, 1'b1);
    // a check at an edge sees what settled before it; current lags the load a cycle
    step(4);
    `CHK("code", 5'(code_of[k]), display_code)
    `CHK("disable", 1'b1, output_disable)
    if (k != 0)
    begin
      fault_clear <= 1'b1;
      step(3);
      `CHK("refused clear", 1'b1, fault_active)
    end
    set_cause(k, 1'b0);
    fault_clear <= 1'b1;
    step(3);
    `CHK("cleared", 1'b0, fault_active)
    `CHK("code after clear", 5'h00, display_code)
    fault_clear <= 1'b0;
    step(1);
  endtask

  initial
  begin
    #500000;
    errors = errors + 1;
    wrap_up();
  end

  initial
  begin
    step(3);
    rstn <= 1'b1;
    for (int i = 0; i < 30; i++)
    begin
      step(1);
      load_pct <= 10'(($random(seed) & 32'h7fff_ffff) % 150);
      bus_volts <= 10'(180 + ($random(seed) & 32'h7fff_ffff) % 221);
      terminal_in[2:0] <= 3'($random(seed));
      input_function_select[4:0] <= 5'(($random(seed) & 32'h7fff_ffff) % 19);
      reference_loss_action <= 2'($random(seed));
    end
    bus_volts <= 10'h190;
    step(3);
    bus_volts <= 10'h0B4;
    step(3);
    `CHK("no fault in range", 1'b0, fault_active)
    bus_volts <= 10'h12C;
    for (int k = 0; k < 14; k++)
      trip(k);
    ground_fault <= 1'b1;
    heatsink_hot <= 1'b1;
    step(3);
    `CHK("priority", 5'(fault_pkg::code_ground), display_code)
    set_cause(1, 1'b0);
    set_cause(4, 1'b0);
    fault_clear <= 1'b1;
    step(3);
    fault_clear <= 1'b0;
    load_pct <= 10'h0C8;
    step(15);
    `CHK("short overload", 1'b0, fault_active)
    load_pct <= 10'h064;
    step(2);
    load_pct <= 10'h096;
    n = 0;
    while (fault_active !== 1'b1 && n < 60)
    begin
      step(1);
      n++;
    end
    `CHK("overload time", 1'b1, 1'(n >= 21 && n <= 26))
    step(2);
    `CHK("overload code", 5'(fault_pkg::code_overload_trip), display_code)
    load_pct <= 10'h064;
    fault_clear <= 1'b1;
    step(3);
    fault_clear <= 1'b0;
    cutoff_in <= 1'b1;
    #1;
    `CHK("cutoff now", 1'b1, output_disable)
    step(3);
    `CHK("cutoff shown", 5'(fault_pkg::code_cutoff), display_code)
    forward_run_input <= 1'b0;
    reverse_run_input <= 1'b1;
    cutoff_in <= 1'b0;
    #1;
    `CHK("resume", 1'b0, output_disable)
    for (int a = 0; a < 3; a++)
    begin
      step(1);
      ref_external <= 1'b1;
      ref_present <= 1'b0;
      reference_loss_action <= 2'(a);
      step(3);
      `CHK("hold", 1'(a == 0), hold_last_freq)
      `CHK("coast", 1'(a == 1), output_disable)
      `CHK("decel", 1'(a == 2), decel_stop)
    end
    ref_present <= 1'b1;
    step(3);
    `CHK("reference back", 1'b0, decel_stop)
    wrap_up();
  end
endmodule
